/* tsq_map.svh */
/*
  Constants for the trigger sequencer: program layout, field positions,
  reset values and timing counts.
  Assumes it is included by bare name from the sequencer sources.
*/
`ifndef TSQ_MAP_SVH
`define TSQ_MAP_SVH

// ----------------------------------------------------------------
// Program sizes
// ----------------------------------------------------------------
`define TSQ_NUM_STAGES      4
`define TSQ_NUM_MATCHERS    4
`define TSQ_NUM_COUNTERS    2
`define TSQ_NUM_CLAUSES     4
`define TSQ_BUS_WIDTH       32
`define TSQ_CNT_WIDTH       16
`define TSQ_DLY_WIDTH       16

// ----------------------------------------------------------------
// Event source mask layout: matchers in low bits, counters above
// ----------------------------------------------------------------
`define TSQ_EV_MATCH_LSB    0
`define TSQ_EV_CNT_LSB      4
`define TSQ_EV_WIDTH        6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TSQ_STAGE_FIRST     2'h0
`define TSQ_CNT_RESET       16'h0000

// ----------------------------------------------------------------
// Timing: time-mode counters tick once per microsecond
// ----------------------------------------------------------------
`define TSQ_CLK_MHZ         50
`define TSQ_TICK_NS         1000
`define TSQ_TICK_CYCLES     ((`TSQ_TICK_NS * `TSQ_CLK_MHZ) / 1000)

`endif

/* tsq_pkg.sv */
/*
  Types shared by the trigger sequencer modules.
  Assumes tsq_map.svh is available on the include path.
*/
`include "tsq_map.svh"

package tsq_pkg;

  // ----------------------------------------------------------------
  // Counter operation requested by an action
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    TSQ_CNT_NONE  = 2'h0,
    TSQ_CNT_INC   = 2'h1,
    TSQ_CNT_RESET = 2'h2
  } tsq_cnt_op_t;

  // ----------------------------------------------------------------
  // Run state of the sequencer, Gray along idle-run-post-done
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    TSQ_IDLE = 2'h0,
    TSQ_RUN  = 2'h1,
    TSQ_POST = 2'h3,
    TSQ_DONE = 2'h2
  } tsq_run_t;

  // ----------------------------------------------------------------
  // One pattern matcher: value and care mask
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [`TSQ_BUS_WIDTH-1:0] value;
    logic [`TSQ_BUS_WIDTH-1:0] care;
  } tsq_match_cfg_t;

  // ----------------------------------------------------------------
  // One counter: mode and terminal value
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic                      time_mode;
    logic [`TSQ_CNT_WIDTH-1:0] terminal;
  } tsq_cnt_cfg_t;

  // ----------------------------------------------------------------
  // Compound action grouped under one event
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic        trigger;
    logic        store;
    logic        jump;
    logic [1:0]  jump_to;
    tsq_cnt_op_t cnt_op0;
    tsq_cnt_op_t cnt_op1;
  } tsq_action_t;

  // ----------------------------------------------------------------
  // One clause: compound event (OR of members, optional inversion)
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic                     used;
    logic [`TSQ_EV_WIDTH-1:0] members;
    logic [`TSQ_EV_WIDTH-1:0] invert;
    tsq_action_t              action;
  } tsq_clause_t;

  // ----------------------------------------------------------------
  // One stage: ordered clauses plus a fallback
  // ----------------------------------------------------------------
  typedef struct packed
  {
    tsq_clause_t [`TSQ_NUM_CLAUSES-1:0] clauses;
    logic                               has_fallback;
    tsq_action_t                        fallback;
  } tsq_stage_t;

endpackage

/* tsq_matcher.sv */
/*
  Pattern matcher bank: compares the probed bus with per-matcher
  value and care mask.
  Assumes the probed bus is synchronous to mclk_in.
*/
`timescale 1ns/1ps
`include "tsq_map.svh"

module tsq_matcher
  import tsq_pkg::*;
#(
  parameter int NUM_MATCHERS = `TSQ_NUM_MATCHERS
)
(
  // Probed bus and program
  input  wire logic [`TSQ_BUS_WIDTH-1:0] bus_in,
  input  wire tsq_match_cfg_t            cfg_in [NUM_MATCHERS],
  // Match results
  output logic [NUM_MATCHERS-1:0]        hit_out
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_MATCHERS < 1)
  begin : g_bad
    $error("tsq_matcher needs at least one matcher");
  end

  // ----------------------------------------------------------------
  // Comparison: any cared bit that differs breaks the match
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_MATCHERS; i++)
    begin
      hit_out[i] = ~|((bus_in ^ cfg_in[i].value) & cfg_in[i].care);  // [R3]
    end
  end

endmodule

/* tsq_counter.sv */
/*
  One event counter: counts occurrences or microsecond ticks and
  flags when the terminal value is reached.
  Assumes op_in is a one-cycle request from the sequencer.
*/
`timescale 1ns/1ps
`include "tsq_map.svh"

module tsq_counter
  import tsq_pkg::*;
#(
  parameter int CNT_WIDTH = `TSQ_CNT_WIDTH
)
(
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  // Control
  input  wire logic                 clear_in,
  input  wire tsq_cnt_op_t          op_in,
  input  wire tsq_cnt_cfg_t         cfg_in,
  // Result
  output logic                      reached_out,
  output logic [CNT_WIDTH-1:0]      count_out
);

  localparam int TICKS = (`TSQ_TICK_CYCLES < 1) ? 1 : `TSQ_TICK_CYCLES;

  if (CNT_WIDTH != `TSQ_CNT_WIDTH)
  begin : g_bad
    $error("tsq_counter width must match the terminal field");
  end

  logic [CNT_WIDTH-1:0] count;
  logic [CNT_WIDTH-1:0] next_count;
  logic [7:0]           tick;
  logic [7:0]           next_tick;

  // ----------------------------------------------------------------
  // Next count: reset beats increment; time mode runs on its own
  // ----------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    next_tick  = tick;
    if (clear_in || op_in == TSQ_CNT_RESET)
    begin
      next_count = `TSQ_CNT_RESET;
      next_tick  = 8'h00;
    end
    else if (count != cfg_in.terminal)
    begin
      if (cfg_in.time_mode)
      begin
        // Saturate at terminal so the event holds once reached
        if (tick == 8'(TICKS - 1))
        begin
          next_tick  = 8'h00;
          next_count = count + 1'b1;                                  // [R4]
        end
        else
        begin
          next_tick = tick + 8'h01;
        end
      end
      else if (op_in == TSQ_CNT_INC)
      begin
        next_count = count + 1'b1;                                    // [R4]
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      count <= `TSQ_CNT_RESET;
      tick  <= 8'h00;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

  assign reached_out = (count == cfg_in.terminal);                   // [R4]
  assign count_out   = count;

endmodule

/* tsq_sequencer.sv */
/*
  Trigger sequencer top: holds the active stage, evaluates the
  active stage's clauses on each state clock and fires trigger,
  store-gate, stage-jump and counter actions.
  Assumes the program inputs are held steady while running, and
  that state_clk_in marks one valid state-clock sample per mclk_in cycle it is high.
*/
`timescale 1ns/1ps
`include "tsq_map.svh"

// What this block does
// R1 - Program holds at most four stages, numbered from the first.
// R2 - Simple event is one of four matchers or a counter at terminal.
// R3 - Matcher compares bus to value with don't-care bits, all must agree.
// R4 - Counter event true once count, of time or occurrences, reaches terminal.
// R5 - Actions are trigger, store gate, stage jump and counter control.
// R6 - After trigger, storage stops once the post-trigger delay elapses.
// R7 - Compound event is the OR of its member simple events.
// R8 - Program never nests compound events or compound actions.
// R9 - Inverted matcher event is true when any cared field mismatches.
// R10 - Inverted counter event is true until the counter reaches terminal.
// R11 - Inversion only applies to members, never to a whole compound event.
// R12 - All actions of a compound action execute on the same state clock.
// R13 - Active stage evaluates all clauses and runs every true clause's actions.
// R14 - If no clause is true, the stage's fallback action runs.
// R15 - A stage has at most one fallback; clause count bounded by storage.
// R16 - Only one stage is active; inactive stages are ignored.
// R17 - Stage jump activates target and deactivates the jumping stage.
// R18 - Starting acquisition makes the first stage active.
// R19 - Conflicting jumps or counter operations: the earliest defined wins.
// R20 - With no store gating in the program, every state clock is stored.
// R21 - Active stage is registered, so a jump applies from the next state clock.
module tsq_sequencer
  import tsq_pkg::*;
#(
  parameter int NUM_STAGES  = `TSQ_NUM_STAGES,
  parameter int NUM_CLAUSES = `TSQ_NUM_CLAUSES
)
(
  // Clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  // Run control
  input  wire logic                      start_in,
  input  wire logic                      state_clk_in,
  // Probed bus
  input  wire logic [`TSQ_BUS_WIDTH-1:0] bus_in,
  // Program
  input  wire tsq_match_cfg_t            match_cfg_in [`TSQ_NUM_MATCHERS],
  input  wire tsq_cnt_cfg_t              cnt_cfg_in [`TSQ_NUM_COUNTERS],
  input  wire tsq_stage_t                stage_cfg_in [NUM_STAGES],
  input  wire logic                      gate_used_in,
  input  wire logic [`TSQ_DLY_WIDTH-1:0] post_delay_in,
  // Status and strobes
  output logic [1:0]                     stage_out,
  output logic                           running_out,
  output logic                           triggered_out,
  output logic                           store_out,
  output logic                           done_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_STAGES < 1 || NUM_STAGES > `TSQ_NUM_STAGES)                 // [R1]
  begin : g_bad_stages
    $error("tsq_sequencer supports one to four stages");
  end
  if (NUM_CLAUSES != `TSQ_NUM_CLAUSES)
  begin : g_bad_clauses
    $error("tsq_sequencer clause count must match the stage type");
  end

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  logic [`TSQ_NUM_MATCHERS-1:0] match_hit;
  logic [`TSQ_NUM_COUNTERS-1:0] cnt_reached;
  logic [`TSQ_EV_WIDTH-1:0]     events;
  tsq_cnt_op_t                  cnt_op [`TSQ_NUM_COUNTERS];
  logic                         cnt_clear;

  tsq_matcher #(
    .NUM_MATCHERS (`TSQ_NUM_MATCHERS)
  ) u_matcher (
    .bus_in       (bus_in),
    .cfg_in       (match_cfg_in),
    .hit_out      (match_hit)
  );

  // Counters cleared at start so inverted counter events begin true
  for (genvar c = 0; c < `TSQ_NUM_COUNTERS; c++)
  begin : g_cnt
    tsq_counter #(
      .CNT_WIDTH   (`TSQ_CNT_WIDTH)
    ) u_counter (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .clear_in    (cnt_clear),
      .op_in       (cnt_op[c]),
      .cfg_in      (cnt_cfg_in[c]),
      .reached_out (cnt_reached[c]),
      .count_out   ()
    );
  end

  assign events = {cnt_reached, match_hit};                           // [R2]

  // ----------------------------------------------------------------
  // Compound event: OR of members, each optionally inverted
  // ----------------------------------------------------------------
  function automatic logic clause_true(tsq_clause_t cl, logic [`TSQ_EV_WIDTH-1:0] ev);
    // Inversion is per member only, there is no whole-event invert
    clause_true = cl.used && |(cl.members & (ev ^ cl.invert));        // [R7] [R9] [R10] [R11]
  endfunction

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  tsq_run_t                  run;
  tsq_run_t                  next_run;
  logic [1:0]                stage;
  logic [1:0]                next_stage;
  logic [`TSQ_DLY_WIDTH-1:0] delay;
  logic [`TSQ_DLY_WIDTH-1:0] next_delay;
  logic                      next_triggered;
  logic                      triggered;
  logic                      next_store;
  logic                      next_done;

  // Merged actions of the active stage for this state clock
  logic                      fire_trigger;
  logic                      fire_store;
  logic                      jump_taken;
  logic [1:0]                jump_target;
  tsq_stage_t                act_stage;
  logic                      any_true;

  // ----------------------------------------------------------------
  // Action merge: every true clause fires, earliest wins on conflict
  // ----------------------------------------------------------------
  always_comb
  begin
    tsq_clause_t cl;
    cl           = '0;
    act_stage    = stage_cfg_in[stage];                               // [R16]
    fire_trigger = 1'b0;
    fire_store   = 1'b0;
    jump_taken   = 1'b0;
    jump_target  = stage;
    any_true     = 1'b0;
    for (int c = 0; c < `TSQ_NUM_COUNTERS; c++)
    begin
      cnt_op[c] = TSQ_CNT_NONE;
    end
    if ((run == TSQ_RUN || run == TSQ_POST) && state_clk_in)
    begin
      for (int k = 0; k < NUM_CLAUSES; k++)                           // [R13]
      begin
        cl = act_stage.clauses[k];
        if (clause_true(cl, events))
        begin
          any_true     = 1'b1;
          // Whole compound action applies on this same state clock
          fire_trigger = fire_trigger | cl.action.trigger;            // [R5] [R12]
          fire_store   = fire_store | cl.action.store;
          if (cl.action.jump && !jump_taken)                          // [R19]
          begin
            jump_taken  = 1'b1;
            jump_target = cl.action.jump_to;
          end
          if (cnt_op[0] == TSQ_CNT_NONE)                              // [R19]
          begin
            cnt_op[0] = cl.action.cnt_op0;
          end
          if (cnt_op[1] == TSQ_CNT_NONE)
          begin
            cnt_op[1] = cl.action.cnt_op1;
          end
        end
      end
      // Fallback only when nothing matched; the type holds just one
      if (!any_true && act_stage.has_fallback)                        // [R14] [R15]
      begin
        fire_trigger = act_stage.fallback.trigger;
        fire_store   = act_stage.fallback.store;
        jump_taken   = act_stage.fallback.jump;
        jump_target  = act_stage.fallback.jump ? act_stage.fallback.jump_to : stage;
        cnt_op[0]    = act_stage.fallback.cnt_op0;
        cnt_op[1]    = act_stage.fallback.cnt_op1;
      end
    end
  end

  assign cnt_clear = start_in;

  // ----------------------------------------------------------------
  // Next run state, stage, delay and strobes
  // ----------------------------------------------------------------
  always_comb
  begin
    next_run       = run;
    next_stage     = stage;
    next_delay     = delay;
    next_triggered = triggered;
    next_store     = 1'b0;
    next_done      = 1'b0;
    case (run)
      TSQ_IDLE,
      TSQ_DONE:
      begin
        next_done = (run == TSQ_DONE);
      end
      TSQ_RUN,
      TSQ_POST:
      begin
        if (state_clk_in)
        begin
          // Storage is ungated when the program never uses the gate
          next_store = gate_used_in ? fire_store : 1'b1;              // [R20] [R5]
          if (jump_taken && {1'b0, jump_target} < 3'(NUM_STAGES))
          begin
            next_stage = jump_target;                                 // [R17] [R21]
          end
          if (run == TSQ_POST)
          begin
            // Delay counted in state clocks; zero stops right away
            if (delay == '0)
            begin
              next_run   = TSQ_DONE;                                  // [R6]
              next_store = 1'b0;
              next_done  = 1'b1;
            end
            else
            begin
              next_delay = delay - 1'b1;
            end
          end
          else if (fire_trigger)
          begin
            next_triggered = 1'b1;
            next_delay     = post_delay_in;                           // [R6]
            next_run       = TSQ_POST;
          end
        end
      end
      default:
      begin
        next_run = TSQ_IDLE;
      end
    endcase
    // Start wins over everything and enters the first stage
    if (start_in)
    begin
      next_run       = TSQ_RUN;
      next_stage     = `TSQ_STAGE_FIRST;                              // [R18]
      next_triggered = 1'b0;
      next_delay     = '0;
      next_store     = 1'b0;
      next_done      = 1'b0;
    end
  end

  // The post-trigger phase keeps evaluating stages for counters
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      run           <= TSQ_IDLE;
      stage         <= `TSQ_STAGE_FIRST;
      delay         <= '0;
      triggered     <= 1'b0;
      stage_out     <= `TSQ_STAGE_FIRST;
      running_out   <= 1'b0;
      triggered_out <= 1'b0;
      store_out     <= 1'b0;
      done_out      <= 1'b0;
    end
    else
    begin
      run           <= next_run;
      stage         <= next_stage;                                    // [R21]
      delay         <= next_delay;
      triggered     <= next_triggered;
      stage_out     <= next_stage;
      running_out   <= (next_run == TSQ_RUN) || (next_run == TSQ_POST);
      triggered_out <= next_triggered;
      store_out     <= next_store;
      done_out      <= next_done;
    end
  end

endmodule

/* tsq_sequencer_properties.sv */
/*
  Checker for the trigger sequencer, watching only its top ports.
  Assumes it is bound to tsq_sequencer by the statement at its foot.
*/
`timescale 1ns/1ps

module tsq_sequencer_checker
(
  // Clock, reset and control
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic       state_clk_in,
  input  wire logic       gate_used_in,
  // Status and strobes
  input  wire logic [1:0] stage_out,
  input  wire logic       running_out,
  input  wire logic       triggered_out,
  input  wire logic       store_out,
  input  wire logic       done_out
);
  // ----------------------------------------------------------------
  // Properties, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_start_first_stage: assert property (start_in |=> stage_out == 2'h0 && running_out && !triggered_out && !done_out)
    else $error("start did not restart at the first stage");
  a_stage_needs_clock: assert property (!state_clk_in && !start_in |=> $stable(stage_out))
    else $error("stage moved without a state clock");
  a_idle_ignores_clock: assert property (!running_out && !start_in |=> !store_out && $stable(stage_out))
    else $error("state clock acted while not running");
  a_ungated_store_all: assert property (running_out && !triggered_out && state_clk_in && !gate_used_in && !start_in
    |=> store_out)
    else $error("ungated sample not stored");
  a_store_has_cause: assert property (store_out |-> $past(state_clk_in) && $past(running_out))
    else $error("store strobe without a sampled state clock");
  a_trigger_stays_set: assert property (triggered_out && !start_in |=> triggered_out)
    else $error("trigger flag dropped without start");
  a_done_follows_trig: assert property ($rose(done_out) |-> $past(triggered_out) && $past(state_clk_in))
    else $error("acquisition stopped without trigger and state clock");
  a_done_stops_run: assert property (done_out |-> !running_out && triggered_out)
    else $error("done while still running");

  // Main scenarios reached
  c_trigger: cover property ($rose(triggered_out));
  c_done: cover property ($rose(done_out));
  c_last_stage: cover property ($changed(stage_out) && stage_out == 2'h3);
endmodule

bind tsq_sequencer tsq_sequencer_checker chk_u (.mclk_in, .rst_n_in, .start_in, .state_clk_in, .gate_used_in,
  .stage_out, .running_out, .triggered_out, .store_out, .done_out);

/* tsq_bus_model.sv */
/*
  Behavioural model of the probed bus of the system under test.
  Assumes send is entered just after a rising edge of mclk_in.
*/
`timescale 1ns/1ps

module tsq_bus_model
(
  // Clock
  input  wire logic  mclk_in,
  // Probed bus
  output logic [31:0] bus_out,
  output logic        state_clk_out
);
  // Quiet bus at time zero
  initial
  begin
    bus_out = 32'h0000_0000;
    state_clk_out = 1'b0;
  end

  // One sample per call; outside a burst the bus shows the inverse,
  // so a stale value can never pass for a fresh sample
  task send(input logic [31:0] v, input logic last);
    state_clk_out = 1'b1;
    bus_out = v;
    @(posedge mclk_in);
    #1;
    if (last)
    begin
      state_clk_out = 1'b0;
      bus_out = ~v;
    end
  endtask
endmodule

/* tsq_sequencer_tb.sv */
/*
  Self-checking testbench for the trigger sequencer.
  Assumes the design sources and tsq_pkg are compiled before it.
*/
`timescale 1ns/1ps

module tsq_sequencer_tb
  import tsq_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and program
  // ----------------------------------------------------------------
  localparam logic [31:0] NONE = 32'h0000_0055;
  logic           mclk_in;
  logic           rst_n_in;
  logic           start_in;
  logic           gate_used_in;
  logic [15:0]    post_delay_in;
  logic           state_clk;
  logic [31:0]    bus;
  logic [1:0]     stage_out;
  logic           running_out;
  logic           triggered_out;
  logic           store_out;
  logic           done_out;
  tsq_match_cfg_t mcf [4];
  tsq_cnt_cfg_t   ccf [2];
  tsq_stage_t     stg [4];
  int             errors;
  int             checks_done;
  int             n;

  tsq_bus_model bus_u (.mclk_in(mclk_in), .bus_out(bus), .state_clk_out(state_clk));

  tsq_sequencer dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start_in), .state_clk_in(state_clk),
    .bus_in(bus), .match_cfg_in(mcf), .cnt_cfg_in(ccf), .stage_cfg_in(stg), .gate_used_in(gate_used_in),
    .post_delay_in(post_delay_in), .stage_out(stage_out), .running_out(running_out),
    .triggered_out(triggered_out), .store_out(store_out), .done_out(done_out));

  // Free-running 50 MHz clock
  always #10 mclk_in = ~mclk_in;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Flat clause: members and inversion never nest
  function automatic tsq_clause_t cl(input logic [5:0] mem, inv, input logic trg, st, jmp, input logic [1:0] to,
                                     input tsq_cnt_op_t op);
    return '{1'b1, mem, inv, '{trg, st, jmp, to, op, TSQ_CNT_NONE}};
  endfunction

  // Empty program, one fallback at most per stage
  task clr;
    foreach (stg[i]) stg[i] = '0;
    gate_used_in = 1'b0;
  endtask

  task idle(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  task go;
    start_in = 1'b1;
    idle(1);
    start_in = 1'b0;
    chk(stage_out, 2'h0);
    chk(running_out, 1'h1);
  endtask

  task conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_chain;
    clr;
    stg[0].clauses[0] = cl(6'h01, 6'h00, 1'b0, 1'b0, 1'b1, 2'h1, TSQ_CNT_NONE);
    stg[1].clauses[0] = cl(6'h02, 6'h00, 1'b0, 1'b0, 1'b1, 2'h2, TSQ_CNT_NONE);
    go;
    bus_u.send(32'h0000_00A1, 1'b1);
    chk(stage_out, 2'h0);
    chk(store_out, 1'h1);
    idle(3);
    chk(stage_out, 2'h0);
    bus_u.send(32'h0000_00A0, 1'b0);
    chk(stage_out, 2'h1);
    bus_u.send(32'h0000_00A0, 1'b0);
    chk(stage_out, 2'h1);
    bus_u.send(32'h0000_00A1, 1'b1);
    chk(stage_out, 2'h2);
  endtask

  task t_conflict;
    clr;
    stg[0].clauses[0] = cl(6'h01, 6'h00, 1'b0, 1'b0, 1'b1, 2'h2, TSQ_CNT_NONE);
    stg[0].clauses[1] = cl(6'h01, 6'h00, 1'b1, 1'b0, 1'b1, 2'h3, TSQ_CNT_NONE);
    go;
    bus_u.send(32'h0000_00A0, 1'b1);
    chk(stage_out, 2'h2);
    chk(triggered_out, 1'h1);
  endtask

  task t_fallback;
    clr;
    stg[0].clauses[0] = cl(6'h01, 6'h00, 1'b0, 1'b0, 1'b1, 2'h1, TSQ_CNT_NONE);
    stg[0].has_fallback = 1'b1;
    stg[0].fallback = '{1'b0, 1'b0, 1'b1, 2'h3, TSQ_CNT_NONE, TSQ_CNT_NONE};
    go;
    bus_u.send(NONE, 1'b1);
    chk(stage_out, 2'h3);
    go;
    bus_u.send(32'h0000_00A0, 1'b1);
    chk(stage_out, 2'h1);
  endtask

  task t_invert;
    clr;
    stg[0].clauses[0] = cl(6'h03, 6'h01, 1'b0, 1'b0, 1'b1, 2'h1, TSQ_CNT_NONE);
    go;
    bus_u.send(32'h0000_00A0, 1'b1);
    chk(stage_out, 2'h0);
    bus_u.send(32'h0000_01A0, 1'b1);
    chk(stage_out, 2'h1);
  endtask

  task t_gate;
    clr;
    gate_used_in = 1'b1;
    stg[0].clauses[0] = cl(6'h01, 6'h00, 1'b0, 1'b1, 1'b0, 2'h0, TSQ_CNT_NONE);
    go;
    bus_u.send(NONE, 1'b0);
    chk(store_out, 1'h0);
    bus_u.send(32'h0000_00A0, 1'b1);
    chk(store_out, 1'h1);
  endtask

  task t_counter;
    clr;
    ccf[0] = '{1'b0, 16'h0002};
    stg[0].clauses[0] = cl(6'h01, 6'h00, 1'b0, 1'b0, 1'b0, 2'h0, TSQ_CNT_INC);
    stg[0].clauses[1] = cl(6'h10, 6'h00, 1'b0, 1'b0, 1'b1, 2'h1, TSQ_CNT_NONE);
    stg[0].clauses[2] = cl(6'h10, 6'h10, 1'b1, 1'b0, 1'b0, 2'h0, TSQ_CNT_NONE);
    go;
    bus_u.send(32'h0000_00A0, 1'b0);
    chk(triggered_out, 1'h1);
    bus_u.send(32'h0000_00A0, 1'b1);
    chk(stage_out, 2'h0);
    idle(2);
    bus_u.send(NONE, 1'b1);
    chk(stage_out, 2'h1);
    rst_n_in = 1'b0;
    idle(2);
    rst_n_in = 1'b1;
    chk({stage_out, running_out, triggered_out, store_out, done_out}, 6'h00);
  endtask

  task t_post;
    clr;
    post_delay_in = 16'h0002;
    stg[0].clauses[0] = cl(6'h01, 6'h00, 1'b1, 1'b0, 1'b0, 2'h0, TSQ_CNT_NONE);
    go;
    bus_u.send(32'h0000_00A0, 1'b1);
    chk({triggered_out, done_out}, 2'h2);
    n = 0;
    while (done_out !== 1'b1 && n < 8)
    begin
      bus_u.send(NONE, 1'b1);
      n++;
    end
    chk(n, 32'h3);
    chk(running_out, 1'h0);
    bus_u.send(NONE, 1'b1);
    chk(store_out, 1'h0);
    go;
    chk({triggered_out, done_out}, 2'h0);
  endtask

  task t_time;
    clr;
    ccf[1] = '{1'b1, 16'h0001};
    stg[0].clauses[0] = cl(6'h20, 6'h00, 1'b0, 1'b0, 1'b1, 2'h2, TSQ_CNT_NONE);
    go;
    idle(49);
    bus_u.send(NONE, 1'b1);
    chk(stage_out, 2'h0);
    bus_u.send(NONE, 1'b1);
    chk(stage_out, 2'h2);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    mclk_in = 1'b0;
    rst_n_in = 1'b0;
    start_in = 1'b0;
    post_delay_in = 16'h0100;
    errors = 0;
    checks_done = 0;
    foreach (mcf[i]) mcf[i] = '{32'h0000_00A0 + i, 32'hFFFF_FFFF};
    foreach (ccf[i]) ccf[i] = '0;
    clr;
    idle(12);
    rst_n_in = 1'b1;
    chk({stage_out, running_out, triggered_out, store_out, done_out}, 6'h00);
    t_chain;
    t_conflict;
    t_fallback;
    t_invert;
    t_gate;
    t_counter;
    t_post;
    t_time;
    conclude;
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    #100000;
    errors++;
    conclude;
  end
endmodule
